/* File: design/spsc_commander.sv */
`include "spsc_consts.svh"

module spsc_commander #(
    parameter int BIT_CYCLES = `SPSC_BIT_CYCLES,
    parameter int NUM_USERS  = `SPSC_NUM_USERS
) (
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic        serialRx,
    output logic             serialTx,
    input  wire logic        localReq,
    input  wire logic [1:0]  localUser,
    input  wire logic [4:0]  localChan,
    output logic             localReady,
    output logic [19:0]      routeChan,
    output logic [3:0]       videoOff
);
    if (NUM_USERS != `SPSC_NUM_USERS) begin : g_chk_users
        $error("code table serves exactly four user ports");
    end

    ////////////////////////////////////////////////////////////////////////
    // Code table

    function automatic spsc_pkg::spsc_cmd_t decodeByte(input logic [7:0] b);
        spsc_pkg::spsc_cmd_t c;
        c = '0;
        if (b[7:4] >= `SPSC_LOW_NIBBLE_MIN && b[7:4] <= `SPSC_LOW_NIBBLE_MAX) begin
            c.ok   = 1'b1;
            c.user = 2'(b[7:4] - `SPSC_LOW_NIBBLE_MIN);
            c.chan = {1'b0, b[3:0]} + `SPSC_FIRST_CHAN;
        end else if (b[7:4] == `SPSC_HIGH_NIBBLE_A || b[7:4] == `SPSC_HIGH_NIBBLE_B) begin
            c.ok   = 1'b1;
            c.user = {b[7], b[3]};
            c.chan = `SPSC_FIRST_HIGH_CHAN + {2'h0, b[2:0]};
        end else if (b >= `SPSC_OFF_CODE_BASE && b <= `SPSC_OFF_CODE_LAST) begin
            c.ok   = 1'b1;
            c.user = 2'(b - `SPSC_OFF_CODE_BASE);
            c.chan = `SPSC_VIDEO_OFF;
        end
        return c;
    endfunction

    function automatic logic [7:0] encodeCode(input logic [1:0] user, input logic [4:0] chan);
        logic [7:0] code;
        code = 8'h00;
        if (chan == `SPSC_VIDEO_OFF) begin
            code = `SPSC_OFF_CODE_BASE + {6'h00, user};
        end else if (chan <= `SPSC_LOW_LAST_CHAN) begin
            code = {2'(user + 2'h1) == 2'h0 ? 4'h4 : {2'h0, 2'(user + 2'h1)},
                    4'(chan - `SPSC_FIRST_CHAN)};
        end else begin
            code = (user[1] ? `SPSC_HIGH_BASE_B : `SPSC_HIGH_BASE_A)
                 + {4'h0, user[0], 3'(chan - `SPSC_FIRST_HIGH_CHAN)};
        end
        return code;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Serial port

    logic [7:0] rxData;
    logic       rxValid;
    logic       txBusy;
    logic       txStart;
    logic       pendValid_reg, pendValid_next;
    logic [7:0] pendByte_reg, pendByte_next;

    spsc_uart #(
        .BIT_CYCLES (BIT_CYCLES)
    ) u_uart (
        .core_clk (core_clk),
        .rstn     (rstn),
        .rxLine   (serialRx),
        .txLine   (serialTx),
        .rxData   (rxData),
        .rxValid  (rxValid),
        .txData   (pendByte_reg),
        .txStart  (txStart),
        .txBusy   (txBusy)
    );

    ////////////////////////////////////////////////////////////////////////
    // Decode and routing

    logic [3:0][4:0] routeChan_reg, routeChan_next;

    wire spsc_pkg::spsc_cmd_t rxCmd = decodeByte(rxData);
    wire serialHit  = rxValid && rxCmd.ok;
    wire localValid = (localChan <= `SPSC_LAST_CHAN);
    wire localDiff  = (routeChan_reg[localUser] != localChan);
    wire localHit   = localReq && localReady && localValid && localDiff;
    wire [7:0] localCode = encodeCode(localUser, localChan);

    // A local switch is only taken with the line idle, so the echo slot is free
    assign localReady = !pendValid_reg && !txBusy && !rxValid;

    always_comb begin
        routeChan_next = routeChan_reg;
        if (serialHit) begin
            routeChan_next[rxCmd.user] = rxCmd.chan;
        end else if (localHit) begin
            routeChan_next[localUser] = localChan;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outgoing byte: echo of a serial command or code of a local switch

    assign txStart = pendValid_reg && !txBusy;

    always_comb begin
        pendValid_next = pendValid_reg;
        pendByte_next  = pendByte_reg;
        if (serialHit) begin
            pendValid_next = 1'b1;
            pendByte_next  = rxData;
        end else if (localHit) begin
            pendValid_next = 1'b1;
            pendByte_next  = localCode;
        end else if (txStart) begin
            pendValid_next = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            routeChan_reg <= {4{`SPSC_RESET_CHAN}};
            pendValid_reg <= 1'b0;
            pendByte_reg  <= 8'h00;
        end else begin
            routeChan_reg <= routeChan_next;
            pendValid_reg <= pendValid_next;
            pendByte_reg  <= pendByte_next;
        end
    end

    assign routeChan = routeChan_reg;
    for (genvar u = 0; u < 4; u++) begin : g_video
        assign videoOff[u] = (routeChan_reg[u] == `SPSC_VIDEO_OFF);
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    logic [3:0][4:0] holdMask;
    always_comb begin
        holdMask = {4{5'h1F}};
        holdMask[rxCmd.user] = 5'h00;
    end

    sequence s_valid_cmd;
        rxValid && rxCmd.ok;
    endsequence

    sequence s_local_take;
        localHit;
    endsequence

    sequence s_frame_begins;
        txStart ##1 (txBusy && !serialTx);
    endsequence

    a_echo_same: assert property (
        s_valid_cmd |=> pendValid_reg && pendByte_reg == $past(rxData))
        else $error("valid command not queued for echo");

    a_echo_leaves: assert property (
        s_valid_cmd ##1 !txBusy |-> s_frame_begins)
        else $error("echo not started");

    a_ignore_junk: assert property (
        rxValid && !rxCmd.ok && !pendValid_reg |=> !pendValid_reg && $stable(routeChan_reg))
        else $error("invalid byte had an effect");

    a_route_taken: assert property (
        s_valid_cmd |=> routeChan_reg[$past(rxCmd.user)] == $past(rxCmd.chan))
        else $error("serial switch not applied");

    a_others_hold: assert property (
        s_valid_cmd |=> (routeChan_reg & $past(holdMask)) == ($past(routeChan_reg) & $past(holdMask)))
        else $error("other user port changed");

    a_user1_table: assert property (
        rxValid && rxData == 8'h60 |=> routeChan_reg[0] == 5'h11 ##0 !videoOff[0])
        else $error("user one high code wrong");

    a_user1_off: assert property (
        rxValid && rxData == 8'h71 |=> videoOff[0])
        else $error("user one video off wrong");

    a_user2_table: assert property (
        rxValid && rxData == 8'h6F |=> routeChan_reg[1] == 5'h18)
        else $error("user two high code wrong");

    a_user3_table: assert property (
        rxValid && rxData == 8'h3A |=> routeChan_reg[2] == 5'h0B)
        else $error("user three low code wrong");

    a_user4_table: assert property (
        rxValid && rxData == 8'h8A |=> routeChan_reg[3] == 5'h13)
        else $error("user four high code wrong");

    a_user4_off: assert property (
        rxValid && rxData == 8'h74 |=> videoOff[3] && routeChan_reg[3] == 5'h00)
        else $error("user four video off wrong");

    a_local_emit: assert property (
        s_local_take |=> pendValid_reg ##1 txBusy)
        else $error("local switch not announced");

    a_local_code: assert property (
        s_local_take |=> decodeByte(pendByte_reg).ok
            && decodeByte(pendByte_reg).user == $past(localUser)
            && decodeByte(pendByte_reg).chan == $past(localChan))
        else $error("announced code does not match switch");

    // A code that matches the present routing must leave routing alone
    a_slave_follows: assert property (
        s_valid_cmd ##0 routeChan_reg[rxCmd.user] == rxCmd.chan |=> $stable(routeChan_reg))
        else $error("repeated command moved routing");

    // Routing never moves without a byte on its way out
    a_move_announced: assert property (
        !$stable(routeChan_reg) |-> pendValid_reg)
        else $error("routing changed with nothing to send");

    a_send_prompt: assert property (
        pendValid_reg && !txBusy |-> s_frame_begins)
        else $error("pending byte held back");

    a_local_junk: assert property (
        localReq && !localValid && !rxValid |=> $stable(routeChan_reg))
        else $error("out of range local channel took effect");

    a_local_same: assert property (
        localReq && !localDiff && !rxValid |=> !$rose(pendValid_reg))
        else $error("unchanged local channel was announced");

    a_user1_first: assert property (
        rxValid && rxData == 8'h10 |=> routeChan_reg[0] == 5'h01)
        else $error("user one first code wrong");

    a_user1_low: assert property (
        rxValid && rxData == 8'h1F |=> routeChan_reg[0] == 5'h10)
        else $error("user one low code wrong");

    a_user1_last: assert property (
        rxValid && rxData == 8'h67 |=> routeChan_reg[0] == 5'h18)
        else $error("user one last code wrong");

    a_user2_first: assert property (
        rxValid && rxData == 8'h20 |=> routeChan_reg[1] == 5'h01)
        else $error("user two first code wrong");

    a_user2_high: assert property (
        rxValid && rxData == 8'h68 |=> routeChan_reg[1] == 5'h11)
        else $error("user two first high code wrong");

    a_user2_off: assert property (
        rxValid && rxData == 8'h72 |=> videoOff[1])
        else $error("user two video off wrong");

    a_user3_first: assert property (
        rxValid && rxData == 8'h30 |=> routeChan_reg[2] == 5'h01)
        else $error("user three first code wrong");

    a_user3_low: assert property (
        rxValid && rxData == 8'h3F |=> routeChan_reg[2] == 5'h10)
        else $error("user three last low code wrong");

    a_user3_high: assert property (
        rxValid && rxData == 8'h87 |=> routeChan_reg[2] == 5'h18)
        else $error("user three high code wrong");

    a_user3_off: assert property (
        rxValid && rxData == 8'h73 |=> videoOff[2])
        else $error("user three video off wrong");

    a_user4_first: assert property (
        rxValid && rxData == 8'h40 |=> routeChan_reg[3] == 5'h01)
        else $error("user four first code wrong");

    a_user4_low: assert property (
        rxValid && rxData == 8'h4F |=> routeChan_reg[3] == 5'h10)
        else $error("user four last low code wrong");

    a_user4_last: assert property (
        rxValid && rxData == 8'h8F |=> routeChan_reg[3] == 5'h18)
        else $error("user four last code wrong");
endmodule

/* File: design/spsc_consts.svh */
`ifndef SPSC_CONSTS_SVH
`define SPSC_CONSTS_SVH

// Serial line settings
`define SPSC_CLK_HZ          100000000
`define SPSC_BAUD_RATE       19200
`define SPSC_DATA_BITS       8
`define SPSC_STOP_BITS       1
`define SPSC_BIT_CYCLES      (`SPSC_CLK_HZ / `SPSC_BAUD_RATE)
`define SPSC_MIN_BIT_CYCLES  16

// Switch geometry
`define SPSC_NUM_USERS       4
`define SPSC_NUM_CHANS       24

// Channel numbers; zero means video off
`define SPSC_VIDEO_OFF       5'h00
`define SPSC_FIRST_CHAN      5'h01
`define SPSC_LOW_LAST_CHAN   5'h10
`define SPSC_FIRST_HIGH_CHAN 5'h11
`define SPSC_LAST_CHAN       5'h18
`define SPSC_RESET_CHAN      5'h01

// Code table bases
`define SPSC_LOW_NIBBLE_MIN  4'h1
`define SPSC_LOW_NIBBLE_MAX  4'h4
`define SPSC_HIGH_BASE_A     8'h60
`define SPSC_HIGH_BASE_B     8'h80
`define SPSC_HIGH_NIBBLE_A   4'h6
`define SPSC_HIGH_NIBBLE_B   4'h8
`define SPSC_OFF_CODE_BASE   8'h71
`define SPSC_OFF_CODE_LAST   8'h74

`endif

/* File: design/spsc_pkg.sv */
package spsc_pkg;

    // Gray order along idle, start, data, stop
    typedef enum logic [1:0] {
        SPSC_IDLE  = 2'h0,
        SPSC_START = 2'h1,
        SPSC_DATA  = 2'h3,
        SPSC_STOP  = 2'h2
    } spsc_ser_state_t;

    typedef struct packed {
        logic       ok;
        logic [1:0] user;
        logic [4:0] chan;
    } spsc_cmd_t;

endpackage

/* File: design/spsc_uart.sv */
`include "spsc_consts.svh"

module spsc_uart #(
    parameter int BIT_CYCLES = `SPSC_BIT_CYCLES
) (
    input  wire logic       core_clk,
    input  wire logic       rstn,
    input  wire logic       rxLine,
    output logic            txLine,
    output logic [7:0]      rxData,
    output logic            rxValid,
    input  wire logic [7:0] txData,
    input  wire logic       txStart,
    output logic            txBusy
);
    localparam int CW = $clog2(BIT_CYCLES);
    localparam logic [CW-1:0] LAST = CW'(BIT_CYCLES - 1);
    localparam logic [CW-1:0] HALF = CW'(BIT_CYCLES / 2 - 1);

    if (BIT_CYCLES < `SPSC_MIN_BIT_CYCLES) begin : g_chk
        $error("bit period too short");
    end

    spsc_pkg::spsc_ser_state_t rxState_reg, rxState_next, txState_reg, txState_next;
    logic [CW-1:0] rxCnt_reg, rxCnt_next, txCnt_reg, txCnt_next;
    logic [2:0]    rxBits_reg, rxBits_next, txBits_reg, txBits_next;
    logic [7:0]    rxShift_reg, rxShift_next, txShift_reg, txShift_next;
    logic          rxValid_next, txLine_next;
    logic [7:0]    rxData_next;

    wire rxEnd = (rxCnt_reg == LAST);
    wire txEnd = (txCnt_reg == LAST);

    ////////////////////////////////////////////////////////////////////////
    // Receiver: always listening, no flow control
    always_comb begin
        rxState_next = rxState_reg;
        rxCnt_next   = rxCnt_reg + 1'b1;
        rxBits_next  = rxBits_reg;
        rxShift_next = rxShift_reg;
        rxValid_next = 1'b0;
        rxData_next  = rxData;
        case (rxState_reg)
            spsc_pkg::SPSC_IDLE: begin
                rxCnt_next = '0;
                if (!rxLine) rxState_next = spsc_pkg::SPSC_START;
            end
            spsc_pkg::SPSC_START: begin
                if (rxCnt_reg == HALF) begin
                    rxCnt_next   = '0;
                    rxBits_next  = 3'h0;
                    rxState_next = rxLine ? spsc_pkg::SPSC_IDLE : spsc_pkg::SPSC_DATA;
                end
            end
            spsc_pkg::SPSC_DATA: begin
                if (rxEnd) begin
                    rxCnt_next   = '0;
                    rxShift_next = {rxLine, rxShift_reg[7:1]};
                    rxBits_next  = rxBits_reg + 3'h1;
                    if (rxBits_reg == 3'h7) rxState_next = spsc_pkg::SPSC_STOP;
                end
            end
            spsc_pkg::SPSC_STOP: begin
                if (rxEnd) begin
                    rxValid_next = rxLine;
                    rxData_next  = rxShift_reg;
                    rxState_next = spsc_pkg::SPSC_IDLE;
                end
            end
            default: rxState_next = spsc_pkg::SPSC_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmitter: start bit, eight data bits LSB first, one stop bit
    always_comb begin
        txState_next = txState_reg;
        txCnt_next   = txEnd ? '0 : txCnt_reg + 1'b1;
        txBits_next  = txBits_reg;
        txShift_next = txShift_reg;
        case (txState_reg)
            spsc_pkg::SPSC_IDLE: begin
                txCnt_next = '0;
                if (txStart) begin
                    txShift_next = txData;
                    txState_next = spsc_pkg::SPSC_START;
                end
            end
            spsc_pkg::SPSC_START: begin
                txBits_next = 3'h0;
                if (txEnd) txState_next = spsc_pkg::SPSC_DATA;
            end
            spsc_pkg::SPSC_DATA: begin
                if (txEnd) begin
                    txShift_next = {1'b0, txShift_reg[7:1]};
                    txBits_next  = txBits_reg + 3'h1;
                    if (txBits_reg == 3'h7) txState_next = spsc_pkg::SPSC_STOP;
                end
            end
            spsc_pkg::SPSC_STOP: begin
                if (txEnd) txState_next = spsc_pkg::SPSC_IDLE;
            end
            default: txState_next = spsc_pkg::SPSC_IDLE;
        endcase
        case (txState_next)
            spsc_pkg::SPSC_START: txLine_next = 1'b0;
            spsc_pkg::SPSC_DATA:  txLine_next = txShift_next[0];
            default:              txLine_next = 1'b1;
        endcase
    end

    assign txBusy = (txState_reg != spsc_pkg::SPSC_IDLE);

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rxState_reg <= spsc_pkg::SPSC_IDLE;
            txState_reg <= spsc_pkg::SPSC_IDLE;
            rxCnt_reg   <= '0;
            txCnt_reg   <= '0;
            rxBits_reg  <= 3'h0;
            txBits_reg  <= 3'h0;
            rxShift_reg <= 8'h00;
            txShift_reg <= 8'h00;
            rxValid     <= 1'b0;
            rxData      <= 8'h00;
            txLine      <= 1'b1;
        end else begin
            rxState_reg <= rxState_next;
            txState_reg <= txState_next;
            rxCnt_reg   <= rxCnt_next;
            txCnt_reg   <= txCnt_next;
            rxBits_reg  <= rxBits_next;
            txBits_reg  <= txBits_next;
            rxShift_reg <= rxShift_next;
            txShift_reg <= txShift_next;
            rxValid     <= rxValid_next;
            rxData      <= rxData_next;
            txLine      <= txLine_next;
        end
    end

    a_stop_high: assert property (@(posedge core_clk) disable iff (!rstn)
        txState_reg == spsc_pkg::SPSC_STOP |-> txLine)
        else $error("stop bit not high");
endmodule

/* File: verification/spsc_serial_partner.sv */
module spsc_serial_partner #(
    parameter int BIT_CYCLES = 16
) (
    input  wire logic core_clk,
    input  wire logic lineIn,
    output logic      lineOut
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] rxQ [$];
    int         frameErr;

    initial begin
        lineOut  = 1'b1;
        frameErr = 0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sender: call right after a rising edge; after a high stop bit the next frame follows with no gap
    task automatic send_frame(input logic [7:0] data, input logic stopBit);
        lineOut <= 1'b0;
        repeat (BIT_CYCLES) @(posedge core_clk);
        for (int i = 0; i < 8; i++) begin
            lineOut <= data[i];
            repeat (BIT_CYCLES) @(posedge core_clk);
        end
        lineOut <= stopBit;
        repeat (BIT_CYCLES) @(posedge core_clk);
        if (!stopBit) begin
            lineOut <= 1'b1;
            @(posedge core_clk);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Receiver: always listening, no handshake back to the sender
    always begin
        logic [7:0] b;
        @(negedge lineIn);
        repeat (BIT_CYCLES / 2) @(posedge core_clk);
        if (lineIn === 1'b0) begin
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CYCLES) @(posedge core_clk);
                b[i] = lineIn;
            end
            repeat (BIT_CYCLES) @(posedge core_clk);
            if (lineIn !== 1'b1) frameErr++;
            else rxQ.push_back(b);
        end
    end
endmodule

/* File: verification/tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int BITC = 16;

    logic        core_clk;
    logic        rstn;
    logic        serialRx;
    logic        serialTx;
    logic        localReq;
    logic [1:0]  localUser;
    logic [4:0]  localChan;
    logic        localReady;
    logic [19:0] routeChan;
    logic [3:0]  videoOff;
    int          errorCnt;
    int          cmpCount;
    int          expRoute [4];

    spsc_commander #(.BIT_CYCLES(BITC), .NUM_USERS(4)) dut_u (
        .core_clk(core_clk), .rstn(rstn), .serialRx(serialRx), .serialTx(serialTx),
        .localReq(localReq), .localUser(localUser), .localChan(localChan),
        .localReady(localReady), .routeChan(routeChan), .videoOff(videoOff));

    spsc_serial_partner #(.BIT_CYCLES(BITC)) partner_u (
        .core_clk(core_clk), .lineIn(serialTx), .lineOut(serialRx));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            errorCnt++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic logic [7:0] code_of(input int u, input int c);
        logic [7:0] base;
        base = (u < 2) ? 8'h60 : 8'h80;
        if (c == 0) return 8'h71 + 8'(u);
        if (c <= 16) return {4'(u + 1), 4'(c - 1)};
        return base + 8'((u % 2) * 8) + 8'(c - 17);
    endfunction

    function automatic logic [19:0] exp_chans();
        logic [19:0] r;
        for (int u = 0; u < 4; u++) r[5*u +: 5] = 5'(expRoute[u]);
        return r;
    endfunction

    function automatic logic [3:0] exp_off();
        logic [3:0] r;
        for (int u = 0; u < 4; u++) r[u] = (expRoute[u] == 0);
        return r;
    endfunction

    task automatic get_byte(output logic [7:0] b, output logic got);
        got = 1'b0;
        b   = 8'h00;
        for (int i = 0; i < 20 * BITC && !got; i++) begin
            @(negedge core_clk);
            if (partner_u.rxQ.size() > 0) begin
                b   = partner_u.rxQ.pop_front();
                got = 1'b1;
            end
        end
    endtask

    task automatic check_route();
        check(routeChan, exp_chans());
        check(videoOff, exp_off());
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_reset();
        @(negedge core_clk);
        check(serialTx, 1'b1);
        check(localReady, 1'b1);
        check(routeChan, 20'h08421);
        check(videoOff, 4'h0);
        $display("test reset done");
    endtask

    task automatic test_table();
        logic [7:0] b;
        logic       got;
        for (int u = 0; u < 4; u++) begin
            for (int k = 1; k <= 25; k++) begin
                @(posedge core_clk);
                partner_u.send_frame(code_of(u, k % 25), 1'b1);
                get_byte(b, got);
                check(got, 1'b1);
                check(b, code_of(u, k % 25));
                expRoute[u] = k % 25;
                check(routeChan, exp_chans());
                check(videoOff, exp_off());
            end
        end
        $display("test code table done");
    endtask

    task automatic test_invalid();
        logic [7:0] bad [8] = '{8'h00, 8'h0F, 8'h50, 8'h5F, 8'h70, 8'h75, 8'h90, 8'hFF};
        logic [7:0] b;
        logic       got;
        foreach (bad[i]) begin
            @(posedge core_clk);
            partner_u.send_frame(bad[i], 1'b1);
            get_byte(b, got);
            check(got, 1'b0);
            check_route();
        end
        @(posedge core_clk);
        partner_u.send_frame(code_of(0, 5), 1'b0);
        get_byte(b, got);
        check(got, 1'b0);
        check_route();
        $display("test invalid done");
    endtask

    task automatic test_back2back();
        logic [7:0] b;
        logic       got;
        @(posedge core_clk);
        partner_u.send_frame(code_of(1, 5), 1'b1);
        partner_u.send_frame(code_of(2, 20), 1'b1);
        get_byte(b, got);
        check(got, 1'b1);
        check(b, code_of(1, 5));
        get_byte(b, got);
        check(got, 1'b1);
        check(b, code_of(2, 20));
        expRoute[1] = 5;
        expRoute[2] = 20;
        check_route();
        $display("test back to back done");
    endtask

    task automatic do_local(input int u, input int c, input logic sends);
        logic [7:0] b;
        logic       got;
        @(posedge core_clk);
        localUser <= 2'(u);
        localChan <= 5'(c);
        localReq  <= 1'b1;
        do @(negedge core_clk); while (localReady !== 1'b1);
        @(posedge core_clk);
        localReq <= 1'b0;
        if (sends) expRoute[u] = c;
        @(negedge core_clk);
        check_route();
        check(localReady, !sends);
        get_byte(b, got);
        check(got, sends);
        if (sends) check(b, code_of(u, c));
    endtask

    task automatic test_local();
        do_local(2, 24, 1'b1);
        do_local(3, 7, 1'b1);
        do_local(3, 0, 1'b1);
        do_local(3, 0, 1'b0);
        do_local(0, 25, 1'b0);
        do_local(0, 16, 1'b1);
        $display("test local done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic completeRun();
        $display("comparisons %0d mismatches %0d", cmpCount, errorCnt);
        if (errorCnt == 0 && cmpCount > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (80000) @(posedge core_clk);
        errorCnt++;
        completeRun();
    end

    initial begin
        rstn      = 1'b0;
        localReq  = 1'b0;
        localUser = 2'h0;
        localChan = 5'h00;
        errorCnt  = 0;
        cmpCount  = 0;
        foreach (expRoute[i]) expRoute[i] = 1;
        repeat (10) @(posedge core_clk);
        test_reset();
        @(posedge core_clk);
        rstn <= 1'b1;
        test_table();
        test_invalid();
        test_back2back();
        test_local();
        check(partner_u.frameErr, 0);
        completeRun();
    end
endmodule
